// ===== src/fpp_pkg.sv
// Constants for the fuse store and parallel programming port.
//--------
// Operation
//--------
// Operation
// - Programmed fuse reads 0, unprogrammed reads 1, in every fuse byte.
// - Extended byte: boot size bits 2:1, reset vector bit 0, bits 7:3 read 1.
// - High byte: reset disable, debug, serial prog, watchdog, keep EEPROM, brown-out 2:0.
// - Serial prog enable fuse unreachable in serial mode, changed only by parallel port.
// - Low byte: clock div 8 bit 7, clock out bit 6, startup 5:4, source 3:0.
// - Default clock source is internal RC 8 MHz with longest startup time.
// - Chip erase leaves all fuse values unchanged.
// - Fuse writes refused once first memory lock bit is programmed.
// - Fuses latched at power-up and programming entry; changes apply after exit.
// - Keep-EEPROM fuse takes effect immediately once programmed.
// - Three identification bytes at 0x000..0x002, readable even when locked.
// - Calibration byte at high byte of 0x000, copied to trim register every reset.
// - Ready/busy low during program or erase, high when ready.
// - Data bus driven only while active-low output enable is low.
// - Byte select 1 picks low/high byte; byte select 2 picks low/second high.
// - Load strobe action: 00 address, 01 data, 10 command, 11 nothing.
// - Write or output-enable pulse performs the last loaded command.
// - Decode the nine documented command bytes.
// - Flash paged: 32 or 64 words per page, 128 pages.
// - EEPROM 512 bytes in 4-byte pages, address bits 1:0 byte, 8:2 page.
// - Write pulse starts erase or page program and drops ready/busy.
// - Page-load pulse latches data bytes into page buffer at low address word.
package fpp_pkg;
    // --------
    // Fuse layout and defaults
    // --------
    localparam logic [7:0] FPP_EXT_DEFAULT = 8'hf9;
    localparam logic [7:0] FPP_EXT_UNUSED_MASK = 8'hf8;
    localparam logic [7:0] FPP_HIGH_DEFAULT = 8'hdf;
    localparam logic [7:0] FPP_LOW_DEFAULT = 8'h62;
    localparam logic [7:0] FPP_LOCK_DEFAULT = 8'hff;
    localparam int FPP_KEEP_EEPROM_BIT = 3;
    localparam int FPP_SERIAL_PROG_BIT = 5;
    localparam int FPP_LOCK_FIRST_BIT = 0;
    // --------
    // Commands and action codes
    // --------
    localparam logic [7:0] FPP_CMD_ERASE = 8'h80;
    localparam logic [7:0] FPP_CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] FPP_CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] FPP_CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] FPP_CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] FPP_CMD_RD_IDENT = 8'h08;
    localparam logic [7:0] FPP_CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] FPP_CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] FPP_CMD_RD_EEPROM = 8'h03;
    localparam logic [1:0] FPP_ACT_ADDR = 2'h0;
    localparam logic [1:0] FPP_ACT_DATA = 2'h1;
    localparam logic [1:0] FPP_ACT_CMD = 2'h2;
    // --------
    // Identification space and sizes
    // --------
    localparam logic [1:0] FPP_IDENT_0 = 2'h0;
    localparam logic [1:0] FPP_IDENT_1 = 2'h1;
    localparam logic [1:0] FPP_IDENT_2 = 2'h2;
    localparam int FPP_FLASH_PAGES = 128;
    localparam int FPP_EE_BYTES = 512;
    localparam int FPP_EE_PAGE_BYTES = 4;
    // --------
    // Timing
    // --------
    localparam int FPP_CLK_MHZ = 125;
    localparam int FPP_PROG_TIME_US = 4;
    localparam int FPP_PROG_CYCLES = FPP_PROG_TIME_US * FPP_CLK_MHZ;
    typedef enum logic [1:0] {
        FPP_IDLE = 2'b00,
        FPP_BUSY = 2'b01,
        FPP_DONE = 2'b11
    } fpp_state_t;
endpackage

// ===== src/fpp_port.sv
// Fuse store, identification bytes and parallel programming port.
`timescale 1ns/1ps
module fpp_port import fpp_pkg::*; #(
    parameter int WORDS_PER_PAGE = 32,
    parameter int PROG_CYCLES = FPP_PROG_CYCLES,
    parameter logic [7:0] IDENT_0 = 8'h5a, // Arbitrary value
    parameter logic [7:0] IDENT_1 = 8'h12, // Arbitrary value
    parameter logic [7:0] IDENT_2 = 8'h34, // Arbitrary value
    parameter logic [7:0] CAL_BYTE = 8'h80 // Arbitrary value
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic prog_mode,
    input wire logic serial_mode,
    input wire logic load_strobe,
    input wire logic action_code_hi,
    input wire logic action_code_lo,
    input wire logic byte_select_first,
    input wire logic byte_select_second,
    input wire logic write_n,
    input wire logic out_enable_n,
    input wire logic page_load_strobe,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic ready_busy_out,
    output logic [7:0] extended_config_fuses,
    output logic [7:0] high_config_fuses,
    output logic [7:0] low_config_fuses,
    output logic keep_eeprom_on_erase,
    output logic [7:0] osc_trim_register,
    output logic [7:0] lock_bits,
    output logic [7:0] flash_lo_out,
    output logic [7:0] flash_hi_out,
    output logic [15:0] page_addr_out,
    output logic flash_write_pulse,
    output logic eeprom_write_pulse,
    output logic erase_pulse
);
    localparam int WIDX = $clog2(WORDS_PER_PAGE);
    localparam int EIDX = $clog2(FPP_EE_PAGE_BYTES);
    localparam int CW = $clog2(PROG_CYCLES + 1);

    // ------------------------------------------------------------
    // Strobe edge detection
    // ------------------------------------------------------------
    logic load_q, wr_q, oe_q, pl_q, mode_q;
    logic load_rise, wr_fall, pl_rise, mode_rise, mode_fall;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            load_q <= 1'b0;
            wr_q <= 1'b1;
            oe_q <= 1'b1;
            pl_q <= 1'b0;
            mode_q <= 1'b0;
        end else begin
            load_q <= load_strobe;
            wr_q <= write_n;
            oe_q <= out_enable_n;
            pl_q <= page_load_strobe;
            mode_q <= prog_mode;
        end
    end
    assign load_rise = load_strobe && !load_q;
    assign wr_fall = !write_n && wr_q;
    assign pl_rise = page_load_strobe && !pl_q;
    assign mode_rise = prog_mode && !mode_q;
    assign mode_fall = !prog_mode && mode_q;

    // ------------------------------------------------------------
    // Command, address and data latches
    // ------------------------------------------------------------
    logic [7:0] cmd, addr_lo, addr_hi, dat_lo, dat_hi;
    logic [7:0] next_cmd, next_addr_lo, next_addr_hi, next_dat_lo, next_dat_hi;
    fpp_state_t state, next_state;
    always_comb begin
        next_cmd = cmd;
        next_addr_lo = addr_lo;
        next_addr_hi = addr_hi;
        next_dat_lo = dat_lo;
        next_dat_hi = dat_hi;
        // Loads are ignored while busy; the programmer must wait anyway
        if (prog_mode && load_rise && state == FPP_IDLE) begin
            case ({action_code_hi, action_code_lo})
                FPP_ACT_ADDR: begin
                    if (byte_select_first) next_addr_hi = data_in;
                    else next_addr_lo = data_in;
                end
                FPP_ACT_DATA: begin
                    if (byte_select_first) next_dat_hi = data_in;
                    else next_dat_lo = data_in;
                end
                FPP_ACT_CMD: next_cmd = data_in;
                default: ;
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cmd <= 8'h00;
            addr_lo <= 8'h00;
            addr_hi <= 8'h00;
            dat_lo <= 8'hff;
            dat_hi <= 8'hff;
        end else begin
            cmd <= next_cmd;
            addr_lo <= next_addr_lo;
            addr_hi <= next_addr_hi;
            dat_lo <= next_dat_lo;
            dat_hi <= next_dat_hi;
        end
    end

    // ------------------------------------------------------------
    // Page buffers and backing memories
    // ------------------------------------------------------------
    logic [15:0] flash_buf [WORDS_PER_PAGE];
    logic [7:0] ee_buf [FPP_EE_PAGE_BYTES];
    logic [7:0] ee_mem [FPP_EE_BYTES];
    logic [8:0] ee_addr;
    assign ee_addr = {addr_hi[0], addr_lo};
    // Page load writes the buffer slot chosen by the low address bits
    always_ff @(posedge clock) begin
        if (prog_mode && pl_rise && state == FPP_IDLE) begin
            if (cmd == FPP_CMD_WR_FLASH)
                flash_buf[addr_lo[WIDX-1:0]] <= {dat_hi, dat_lo};
            else if (cmd == FPP_CMD_WR_EEPROM)
                ee_buf[addr_lo[EIDX-1:0]] <= dat_lo;
        end
        if (state == FPP_DONE && cmd == FPP_CMD_WR_EEPROM) begin
            for (int i = 0; i < FPP_EE_PAGE_BYTES; i++)
                ee_mem[{ee_addr[8:EIDX], EIDX'(i)}] <= ee_buf[i];
        end
    end

    // ------------------------------------------------------------
    // Fuse and lock store
    // ------------------------------------------------------------
    logic [7:0] fz_ext, fz_high, fz_low, lock, next_fz_ext, next_fz_high, next_fz_low, next_lock;
    logic fuse_locked;
    assign fuse_locked = !lock[FPP_LOCK_FIRST_BIT];
    always_comb begin
        next_fz_ext = fz_ext;
        next_fz_high = fz_high;
        next_fz_low = fz_low;
        next_lock = lock;
        if (prog_mode && wr_fall && state == FPP_IDLE) begin
            if (cmd == FPP_CMD_WR_FUSE && !fuse_locked) begin
                // Serial mode may write the high byte but never its serial bit
                case ({byte_select_second, byte_select_first})
                    2'b00: next_fz_low = dat_lo;
                    2'b01: begin
                        next_fz_high = dat_lo;
                        if (serial_mode)
                            next_fz_high[FPP_SERIAL_PROG_BIT] = fz_high[FPP_SERIAL_PROG_BIT];
                    end
                    2'b10: next_fz_ext = dat_lo | FPP_EXT_UNUSED_MASK;
                    default: ;
                endcase
            end
            if (cmd == FPP_CMD_WR_LOCK)
                next_lock = lock & dat_lo; // Lock bits only go toward programmed
            if (cmd == FPP_CMD_ERASE)
                next_lock = FPP_LOCK_DEFAULT; // fuses untouched
        end
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            // Stored values stand in for the nonvolatile cells at power-up
            fz_ext <= FPP_EXT_DEFAULT;
            fz_high <= FPP_HIGH_DEFAULT;
            fz_low <= FPP_LOW_DEFAULT;
            lock <= FPP_LOCK_DEFAULT;
        end else begin
            fz_ext <= next_fz_ext;
            fz_high <= next_fz_high;
            fz_low <= next_fz_low;
            lock <= next_lock;
        end
    end

    // ------------------------------------------------------------
    // Latched fuse view and calibration copy
    // ------------------------------------------------------------
    logic [7:0] next_ext_l, next_high_l, next_low_l;
    always_comb begin
        next_ext_l = extended_config_fuses;
        next_high_l = high_config_fuses;
        next_low_l = low_config_fuses;
        // Relatch at entry and again on exit so edits apply afterward
        if (mode_rise || mode_fall) begin
            next_ext_l = fz_ext;
            next_high_l = fz_high;
            next_low_l = fz_low;
        end
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            extended_config_fuses <= FPP_EXT_DEFAULT;
            high_config_fuses <= FPP_HIGH_DEFAULT;
            low_config_fuses <= FPP_LOW_DEFAULT;
            osc_trim_register <= CAL_BYTE;
        end else begin
            extended_config_fuses <= next_ext_l;
            high_config_fuses <= next_high_l;
            low_config_fuses <= next_low_l;
            osc_trim_register <= osc_trim_register;
        end
    end
    // Live or latched: programmed (0) in either takes effect at once
    assign keep_eeprom_on_erase = !(fz_high[FPP_KEEP_EEPROM_BIT]
                                  && high_config_fuses[FPP_KEEP_EEPROM_BIT]);
    assign lock_bits = lock;

    // ------------------------------------------------------------
    // Busy sequencer
    // ------------------------------------------------------------
    logic [CW-1:0] cnt, next_cnt;
    logic start_op;
    assign start_op = prog_mode && wr_fall && state == FPP_IDLE
        && (cmd == FPP_CMD_ERASE || cmd == FPP_CMD_WR_FLASH
            || cmd == FPP_CMD_WR_EEPROM || cmd == FPP_CMD_WR_FUSE
            || cmd == FPP_CMD_WR_LOCK);
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            FPP_IDLE: begin
                if (start_op) begin
                    next_state = FPP_BUSY;
                    next_cnt = CW'(PROG_CYCLES - 1);
                end
            end
            FPP_BUSY: begin
                if (cnt == '0) next_state = FPP_DONE;
                else next_cnt = cnt - 1'b1;
            end
            FPP_DONE: next_state = FPP_IDLE;
            default: next_state = FPP_IDLE;
        endcase
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= FPP_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end
    assign ready_busy_out = (state == FPP_IDLE);

    // Single-cycle commit strobes toward the memory arrays
    always_ff @(posedge clock) begin
        if (!nrst) begin
            flash_write_pulse <= 1'b0;
            eeprom_write_pulse <= 1'b0;
            erase_pulse <= 1'b0;
            page_addr_out <= 16'h0000;
            flash_lo_out <= 8'h00;
            flash_hi_out <= 8'h00;
        end else begin
            flash_write_pulse <= state == FPP_DONE && cmd == FPP_CMD_WR_FLASH;
            eeprom_write_pulse <= state == FPP_DONE && cmd == FPP_CMD_WR_EEPROM;
            erase_pulse <= state == FPP_DONE && cmd == FPP_CMD_ERASE;
            page_addr_out <= {addr_hi, addr_lo};
            flash_lo_out <= flash_buf[addr_lo[WIDX-1:0]][7:0];
            flash_hi_out <= flash_buf[addr_lo[WIDX-1:0]][15:8];
        end
    end

    // ------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------
    logic [7:0] next_dout;
    always_comb begin
        next_dout = 8'hff;
        case (cmd)
            FPP_CMD_RD_IDENT: begin // readable regardless of lock
                if (byte_select_first) next_dout = CAL_BYTE;
                else if (addr_lo[1:0] == FPP_IDENT_0) next_dout = IDENT_0;
                else if (addr_lo[1:0] == FPP_IDENT_1) next_dout = IDENT_1;
                else if (addr_lo[1:0] == FPP_IDENT_2) next_dout = IDENT_2;
            end
            FPP_CMD_RD_FUSE: begin
                case ({byte_select_second, byte_select_first})
                    2'b00: next_dout = fz_low;
                    2'b11: next_dout = fz_high;
                    2'b10: next_dout = fz_ext;
                    default: next_dout = lock;
                endcase
            end
            FPP_CMD_RD_FLASH: next_dout = byte_select_first ? flash_hi_out : flash_lo_out;
            FPP_CMD_RD_EEPROM: next_dout = ee_mem[ee_addr];
            default: next_dout = 8'hff;
        endcase
    end
    always_ff @(posedge clock) begin
        if (!nrst) data_out <= 8'hff;
        else data_out <= next_dout;
    end
    assign data_oe = prog_mode && !out_enable_n;
endmodule

// ===== tb/fpp_port_sva.sv
// Port-level checker for the fuse store and parallel programming port.
`timescale 1ns/1ps
module fpp_port_sva import fpp_pkg::*; #(
    parameter int PROG_CYCLES = FPP_PROG_CYCLES,
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input logic clock,
    input logic nrst,
    input logic prog_mode,
    input logic write_n,
    input logic out_enable_n,
    input logic load_strobe,
    input logic data_oe,
    input logic ready_busy_out,
    input logic [7:0] extended_config_fuses,
    input logic [7:0] high_config_fuses,
    input logic [7:0] low_config_fuses,
    input logic keep_eeprom_on_erase,
    input logic [7:0] osc_trim_register,
    input logic [7:0] lock_bits,
    input logic [15:0] page_addr_out,
    input logic flash_write_pulse,
    input logic eeprom_write_pulse,
    input logic erase_pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // Busy cycles, too many for a repetition
    logic [15:0] busy_cnt, next_busy_cnt;
    always_comb next_busy_cnt = ready_busy_out ? 16'h0 : busy_cnt + 16'h1;
    always_ff @(posedge clock) busy_cnt <= !nrst ? 16'h0 : next_busy_cnt;
    // --------
    // Properties
    // --------
    property p_oe; data_oe == (prog_mode && !out_enable_n); endproperty
    property p_busy_start; prog_mode && ready_busy_out && $fell(write_n) |=> !ready_busy_out;
    endproperty
    property p_busy_len; $rose(ready_busy_out) |-> busy_cnt == PROG_CYCLES + 1; endproperty
    property p_pulse_at; (flash_write_pulse || eeprom_write_pulse || erase_pulse)
        |-> ready_busy_out && !$past(ready_busy_out); endproperty
    property p_pulse_one; erase_pulse || flash_write_pulse |=> !erase_pulse && !flash_write_pulse;
    endproperty
    property p_ext_unused;
        (extended_config_fuses & FPP_EXT_UNUSED_MASK) == FPP_EXT_UNUSED_MASK; endproperty
    property p_fuse_hold; prog_mode && $past(prog_mode) && $past(prog_mode, 2)
        |-> $stable(high_config_fuses) && $stable(low_config_fuses); endproperty
    property p_trim; $rose(nrst) |-> osc_trim_register == CAL_BYTE; endproperty
    property p_reset_ready; $rose(nrst) |-> ready_busy_out && lock_bits == FPP_LOCK_DEFAULT;
    endproperty
    property p_keep; !prog_mode && !$past(prog_mode)
        |-> keep_eeprom_on_erase == !high_config_fuses[FPP_KEEP_EEPROM_BIT]; endproperty
    property p_addr_hold; $changed(page_addr_out)
        |-> $past(load_strobe, 2) && !$past(load_strobe, 3); endproperty
    a_oe: assert property (p_oe) else $error("bus enable wrong");
    a_busy_start: assert property (p_busy_start) else $error("no busy after write");
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    a_pulse_at: assert property (p_pulse_at) else $error("commit pulse misplaced");
    a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
    a_ext_unused: assert property (p_ext_unused) else $error("unused bits not 1");
    a_fuse_hold: assert property (p_fuse_hold) else $error("fuse view moved");
    a_trim: assert property (p_trim) else $error("trim not loaded");
    a_reset_ready: assert property (p_reset_ready) else $error("reset state wrong");
    a_keep: assert property (p_keep) else $error("keep flag missing");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    c_erase: cover property (erase_pulse);
    c_flash: cover property (flash_write_pulse);
    c_eeprom: cover property (eeprom_write_pulse);
    c_keep: cover property ($rose(keep_eeprom_on_erase));
endmodule
bind fpp_port fpp_port_sva #(.PROG_CYCLES(PROG_CYCLES), .CAL_BYTE(CAL_BYTE)) u_sva (.*);

// ===== tb/fpp_port_test.sv
// Self-checking bench for the fuse store and parallel programming port.
`timescale 1ns/1ps
module fpp_port_test;
    import fpp_pkg::*;
    localparam logic [7:0] ID0 = 8'h2c; // Arbitrary value
    localparam logic [7:0] ID1 = 8'h71; // Arbitrary value
    localparam logic [7:0] ID2 = 8'h4e; // Arbitrary value
    localparam logic [7:0] CAL = 8'h9b; // Arbitrary value
    logic clock, nrst, prog_mode, serial_mode, load_strobe, action_code_hi, action_code_lo;
    logic byte_select_first, byte_select_second, write_n, out_enable_n, page_load_strobe;
    logic data_oe, ready_busy_out, keep_eeprom_on_erase;
    logic flash_write_pulse, eeprom_write_pulse, erase_pulse, b;
    logic [7:0] data_in, data_out, extended_config_fuses, high_config_fuses, low_config_fuses;
    logic [7:0] osc_trim_register, lock_bits, flash_lo_out, flash_hi_out, d;
    logic [15:0] page_addr_out;
    logic [2:0] seen_pulses = 3'h0;
    logic [7:0] ids [3] = '{ID0, ID1, ID2};
    int num_errors = 0;
    int checked = 0;
    fpp_port #(.PROG_CYCLES(5), .IDENT_0(ID0), .IDENT_1(ID1), .IDENT_2(ID2), .CAL_BYTE(CAL))
    u_dut (.clock, .nrst, .prog_mode, .serial_mode, .load_strobe, .action_code_hi,
        .action_code_lo, .byte_select_first, .byte_select_second, .write_n, .out_enable_n,
        .page_load_strobe, .data_in, .data_out, .data_oe, .ready_busy_out,
        .extended_config_fuses, .high_config_fuses, .low_config_fuses, .keep_eeprom_on_erase,
        .osc_trim_register, .lock_bits, .flash_lo_out, .flash_hi_out, .page_addr_out,
        .flash_write_pulse, .eeprom_write_pulse, .erase_pulse);
    fpp_programmer u_prog (.clock, .ready_busy_out, .data_out, .data_oe, .prog_mode,
        .serial_mode, .load_strobe, .action_code_hi, .action_code_lo, .byte_select_first,
        .byte_select_second, .write_n, .out_enable_n, .page_load_strobe, .data_bus(data_in));
    // --------
    // Clock, pulse log and reporting
    // --------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Commit pulses last one cycle, so they are logged rather than polled
    always @(posedge clock) begin
        seen_pulses <= seen_pulses | {erase_pulse === 1'b1, eeprom_write_pulse === 1'b1,
            flash_write_pulse === 1'b1};
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        num_errors++;
        test_done();
    end
    // --------
    // Test sequence
    // --------
    initial begin
        nrst = 1'b0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        check(ready_busy_out, 1'b1);
        check(extended_config_fuses, 8'hf9);
        check(high_config_fuses, 8'hdf);
        check(low_config_fuses, 8'h62);
        check(osc_trim_register, CAL);
        u_prog.enter();
        u_prog.cmd(FPP_CMD_RD_IDENT);
        for (int i = 0; i < 3; i++) begin
            u_prog.load(FPP_ACT_ADDR, 1'b0, 8'(i));
            u_prog.read_op(1'b0, 1'b0, d);
            check(d, ids[i]);
            u_prog.read_op(1'b0, 1'b1, d);
            check(d, CAL);
        end
        u_prog.cmd(FPP_CMD_RD_FUSE);
        u_prog.read_op(1'b0, 1'b0, d);
        check(d, 8'h62);
        u_prog.read_op(1'b1, 1'b0, d);
        check(d, 8'hf9);
        u_prog.read_op(1'b0, 1'b1, d);
        check(d, 8'hff);
        // Fuse writes; high byte via serial path keeps the serial enable
        u_prog.cmd(FPP_CMD_WR_FUSE);
        u_prog.load(FPP_ACT_DATA, 1'b0, 8'h5e);
        u_prog.write_op(1'b0, 1'b0, b);
        check(b, 1'b1);
        u_prog.set_serial(1'b1);
        u_prog.load(FPP_ACT_DATA, 1'b0, 8'hf7);
        u_prog.write_op(1'b0, 1'b1, b);
        u_prog.set_serial(1'b0);
        check(keep_eeprom_on_erase, 1'b1);
        check(high_config_fuses, 8'hdf);
        u_prog.load(FPP_ACT_DATA, 1'b0, 8'h00);
        u_prog.write_op(1'b1, 1'b0, b);
        u_prog.cmd(FPP_CMD_ERASE);
        u_prog.write_op(1'b0, 1'b0, b);
        check(seen_pulses, 3'b100);
        // Flash page: buffer word, address reuse and idle action
        u_prog.cmd(FPP_CMD_WR_FLASH);
        u_prog.load(FPP_ACT_ADDR, 1'b0, 8'h03);
        u_prog.load(FPP_ACT_DATA, 1'b0, 8'h3c);
        u_prog.load(FPP_ACT_DATA, 1'b1, 8'hc3);
        u_prog.page_load(1'b1);
        check({flash_hi_out, flash_lo_out}, 16'hc33c);
        u_prog.load(FPP_ACT_ADDR, 1'b1, 8'h01);
        u_prog.load(2'h3, 1'b0, 8'h77);
        check(page_addr_out, 16'h0103);
        u_prog.write_op(1'b0, 1'b0, b);
        check(seen_pulses, 3'b101);
        u_prog.cmd(FPP_CMD_RD_FLASH);
        u_prog.read_op(1'b0, 1'b1, d);
        check(d, 8'hc3);
        u_prog.cmd(FPP_CMD_WR_EEPROM);
        u_prog.load(FPP_ACT_ADDR, 1'b0, 8'h05);
        u_prog.load(FPP_ACT_DATA, 1'b0, 8'h5a);
        u_prog.page_load(1'b0);
        u_prog.write_op(1'b0, 1'b0, b);
        check(seen_pulses, 3'b111);
        u_prog.cmd(FPP_CMD_RD_EEPROM);
        u_prog.read_op(1'b0, 1'b0, d);
        check(d, 8'h5a);
        u_prog.leave();
        check(extended_config_fuses, 8'hf8);
        check(high_config_fuses, 8'hd7);
        check(low_config_fuses, 8'h5e);
        // Lock first bit, then a fuse write must be refused
        u_prog.enter();
        u_prog.cmd(FPP_CMD_WR_LOCK);
        u_prog.load(FPP_ACT_DATA, 1'b0, 8'hfe);
        u_prog.write_op(1'b0, 1'b0, b);
        check(lock_bits, 8'hfe);
        u_prog.cmd(FPP_CMD_WR_FUSE);
        u_prog.load(FPP_ACT_DATA, 1'b0, 8'h00);
        u_prog.write_op(1'b0, 1'b0, b);
        u_prog.leave();
        check(low_config_fuses, 8'h5e);
        test_done();
    end
endmodule

// ===== tb/fpp_programmer.sv
// Behavioural model of the external parallel programmer.
`timescale 1ns/1ps
module fpp_programmer import fpp_pkg::*; #(
    parameter int PULSE = 32,
    parameter int ENTRY_WAIT = 6250
) (
    input logic clock,
    input logic ready_busy_out,
    input logic [7:0] data_out,
    input logic data_oe,
    output logic prog_mode,
    output logic serial_mode,
    output logic load_strobe,
    output logic action_code_hi,
    output logic action_code_lo,
    output logic byte_select_first,
    output logic byte_select_second,
    output logic write_n,
    output logic out_enable_n,
    output logic page_load_strobe,
    output logic [7:0] data_bus
);
    logic [7:0] drv = 8'h00;
    logic drv_en = 1'b0;
    initial {prog_mode, serial_mode, load_strobe, page_load_strobe, write_n, out_enable_n} = 6'h03;
    initial {action_code_hi, action_code_lo, byte_select_first, byte_select_second} = 4'h0;
    // Released bus shows the inverse, so a stale value never passes
    assign data_bus = data_oe ? data_out : (drv_en ? drv : ~drv);
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic set_serial(input logic v);
        @(posedge clock);
        serial_mode <= v;
    endtask
    task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
        @(posedge clock);
        {action_code_hi, action_code_lo} <= act;
        byte_select_first <= bs1;
        drv <= d;
        drv_en <= 1'b1;
        hold(2);
        load_strobe <= 1'b1;
        hold(PULSE);
        load_strobe <= 1'b0;
        hold(2);
    endtask
    task automatic cmd(input logic [7:0] c);
        load(FPP_ACT_CMD, 1'b0, c);
    endtask
    task automatic page_load(input logic bs1);
        @(posedge clock);
        byte_select_first <= bs1;
        hold(2);
        page_load_strobe <= 1'b1;
        hold(PULSE);
        page_load_strobe <= 1'b0;
        hold(2);
    endtask
    // Next command only once ready is back
    task automatic write_op(input logic bs2, input logic bs1, output logic busy_seen);
        @(posedge clock);
        {byte_select_second, byte_select_first} <= {bs2, bs1};
        hold(2);
        write_n <= 1'b0;
        busy_seen = 1'b0;
        repeat (PULSE) begin
            @(negedge clock);
            if (ready_busy_out === 1'b0) busy_seen = 1'b1;
        end
        @(posedge clock);
        write_n <= 1'b1;
        for (int i = 0; i < 1000 && ready_busy_out !== 1'b1; i++) @(posedge clock);
        hold(2);
    endtask
    task automatic read_op(input logic bs2, input logic bs1, output logic [7:0] d);
        @(posedge clock);
        {byte_select_second, byte_select_first} <= {bs2, bs1};
        drv_en <= 1'b0;
        hold(2);
        out_enable_n <= 1'b0;
        hold(PULSE);
        @(negedge clock);
        d = data_bus;
        @(posedge clock);
        out_enable_n <= 1'b1;
        hold(2);
    endtask
    task automatic enter();
        @(posedge clock);
        {page_load_strobe, action_code_hi, action_code_lo, byte_select_first} <= 4'h0;
        hold(2);
        prog_mode <= 1'b1;
        hold(ENTRY_WAIT);
    endtask
    task automatic leave();
        @(posedge clock);
        prog_mode <= 1'b0;
        hold(4);
    endtask
endmodule
